/* File: rtl/dsi_pkg.sv */
// Package of constants and types for the DSP instruction subset block.
// Assumes a single 10 MHz clock and an active-high asynchronous reset.
package dsi_pkg;
	localparam int DATA_W      = 24;
	localparam int ACC_W       = 56;
	localparam int PROD_W      = 48;
	localparam int PC_W        = 16;
	localparam int PTR_W       = 16;
	localparam int NREG        = 8;
	localparam int NPTR        = 4;
	localparam int RSEL_W      = 3;
	localparam int PSEL_W      = 2;
	localparam int ASEL_W      = 1;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W        = 3;
	localparam int SIGN_BIT    = 23;
	localparam int SHAMT_W     = 5;
	localparam logic [DATA_W-1:0] REG_RESET = 24'h000000;
	localparam logic [ACC_W-1:0]  ACC_RESET = 56'h00000000000000;
	localparam logic [PC_W-1:0]   PC_RESET  = 16'h0000;
	localparam logic [PTR_W-1:0]  PTR_RESET = 16'h0000;
	localparam logic [PTR_W-1:0]  STEP_RESET = 16'h0001;

	typedef enum logic [4:0] {
		NOP_OP,
		RETURN_OP,
		INTERRUPT_EXIT_OP,
		LOGICAL_LEFT_SHIFT_OP,
		ARITHMETIC_RIGHT_SHIFT_OP,
		LOGICAL_RIGHT_SHIFT_OP,
		SLEEP_OP,
		STORE_OP,
		SUBTRACT_OP,
		DIFFERENCE_MULTIPLY_OP,
		DIFFERENCE_MULTIPLY_ACCUMULATE_OP,
		DIFFERENCE_MULTIPLY_NEGATE_OP,
		DIFFERENCE_MULTIPLY_DEDUCT_OP,
		HALVING_DIFFERENCE_OP,
		POINTER_STEP_DECREMENT_OP,
		SWAP_OP,
		XOR_OP,
		CALL_OP
	} dsi_opcode_type;

	// Operand kinds for source and destination
	typedef enum logic [1:0] {
		KIND_REG,
		KIND_ACC,
		KIND_IMM,
		KIND_MEM
	} dsi_kind_type;

	typedef struct packed {
		dsi_opcode_type          op;
		dsi_kind_type            src_kind;
		dsi_kind_type            dst_kind;
		logic [RSEL_W-1:0]       ra;
		logic [RSEL_W-1:0]       rb;
		logic [RSEL_W-1:0]       rc;
		logic [RSEL_W-1:0]       rd;
		logic [ASEL_W-1:0]       aa;
		logic [ASEL_W-1:0]       ab;
		logic [ASEL_W-1:0]       ad;
		logic [PSEL_W-1:0]       ptr;
		logic [SHAMT_W-1:0]      shamt;
		logic                    cond;
		logic [DATA_W-1:0]       imm;
		logic [PC_W-1:0]         target;
	} dsi_instr_type;

	typedef struct packed {
		logic                    valid;
		logic [PC_W-1:0]         addr;
		logic [DATA_W-1:0]       data;
	} dsi_mem_write_type;
endpackage

/* File: rtl/dsi_shifter.sv */
// Combinational 24-bit shifter for the three shift operations.
// Assumes shift count below the data width; larger counts shift every bit out, giving zero or sign fill.
module dsi_shifter (
	input  wire logic [dsi_pkg::DATA_W-1:0]  value,
	input  wire logic [dsi_pkg::SHAMT_W-1:0] amount,
	input  wire dsi_pkg::dsi_opcode_type     op,
	output logic      [dsi_pkg::DATA_W-1:0]  result
);
	always_comb begin
		case (op)
			dsi_pkg::LOGICAL_LEFT_SHIFT_OP:
				result = value << amount;
			dsi_pkg::ARITHMETIC_RIGHT_SHIFT_OP:
				result = $signed(value) >>> amount;
			dsi_pkg::LOGICAL_RIGHT_SHIFT_OP:
				result = value >> amount;
			default:
				result = value;
		endcase
	end
endmodule

/* File: rtl/dsi_diffmul.sv */
// Combinational fused difference-multiply unit.
// Assumes signed 24-bit operands and a 56-bit accumulator.
module dsi_diffmul (
	input  wire logic [dsi_pkg::DATA_W-1:0] x_a,
	input  wire logic [dsi_pkg::DATA_W-1:0] x_b,
	input  wire logic [dsi_pkg::DATA_W-1:0] y_c,
	input  wire logic [dsi_pkg::ACC_W-1:0]  acc_in,
	input  wire dsi_pkg::dsi_opcode_type    op,
	output logic      [dsi_pkg::ACC_W-1:0]  acc_out
);
	logic signed [dsi_pkg::DATA_W:0]   diff;
	logic signed [dsi_pkg::PROD_W:0]   prod;
	logic signed [dsi_pkg::ACC_W-1:0]  prod_ext;

	always_comb begin
		diff = $signed({x_a[dsi_pkg::SIGN_BIT], x_a})
			- $signed({x_b[dsi_pkg::SIGN_BIT], x_b});
		prod = (dsi_pkg::PROD_W+1)'(diff * $signed(y_c));
		prod_ext = dsi_pkg::ACC_W'(prod);
		case (op)
			dsi_pkg::DIFFERENCE_MULTIPLY_OP:
				acc_out = prod_ext;
			dsi_pkg::DIFFERENCE_MULTIPLY_ACCUMULATE_OP:
				acc_out = acc_in + prod_ext;
			dsi_pkg::DIFFERENCE_MULTIPLY_NEGATE_OP:
				acc_out = -prod_ext;
			dsi_pkg::DIFFERENCE_MULTIPLY_DEDUCT_OP:
				acc_out = acc_in - prod_ext;
			default:
				acc_out = acc_in;
		endcase
	end
endmodule

/* File: rtl/dsi_core.sv */
// Execution stage for a subset of a 24-bit audio DSP core's instructions.
// Assumes one instruction offered per cycle with a valid strobe and
// an interrupt request input held until accepted.
module dsi_core (
	input  wire logic                          REF_CLK,
	input  wire logic                          RST,
	input  wire logic                          INSTR_VALID,
	input  wire dsi_pkg::dsi_instr_type        INSTR,
	input  wire logic                          IRQ,
	input  wire logic [dsi_pkg::PC_W-1:0]      IRQ_VECTOR,
	input  wire logic [dsi_pkg::PTR_W-1:0]     STEP_LOAD_DATA,
	input  wire logic [dsi_pkg::PSEL_W-1:0]    STEP_LOAD_SEL,
	input  wire logic                          STEP_LOAD,
	output logic      [dsi_pkg::PC_W-1:0]      PC,
	output logic                               SLEEPING,
	output logic                               IRQ_TAKEN,
	output logic                               BUSY_N,
	output dsi_pkg::dsi_mem_write_type         MEM_WRITE,
	output logic      [dsi_pkg::DATA_W-1:0]    RESULT,
	output logic                               RESULT_VALID
);
	typedef enum logic [1:0] {
		RUN_STATE,
		SLEEP_STATE,
		HANDLER_STATE
	} dsi_state_type;

	dsi_state_type                     state;
	dsi_state_type                     next_state;
	logic [dsi_pkg::DATA_W-1:0]        regs [dsi_pkg::NREG];
	logic [dsi_pkg::ACC_W-1:0]         accs [2];
	logic [dsi_pkg::PTR_W-1:0]         ptrs [dsi_pkg::NPTR];
	logic [dsi_pkg::PTR_W-1:0]         steps [dsi_pkg::NPTR];
	logic [dsi_pkg::PC_W-1:0]          call_stack [dsi_pkg::STACK_DEPTH];
	logic [dsi_pkg::SP_W-1:0]          call_sp;
	logic [dsi_pkg::PC_W-1:0]          irq_return;
	logic [dsi_pkg::PC_W-1:0]          next_pc;
	logic [dsi_pkg::DATA_W-1:0]        shift_result;
	logic [dsi_pkg::ACC_W-1:0]         diffmul_result;
	logic [dsi_pkg::DATA_W-1:0]        reg_a;
	logic [dsi_pkg::DATA_W-1:0]        reg_b;
	logic [dsi_pkg::DATA_W-1:0]        reg_c;
	logic [dsi_pkg::ACC_W-1:0]         acc_a;
	logic [dsi_pkg::ACC_W-1:0]         acc_b;
	logic [dsi_pkg::ACC_W-1:0]         acc_d;
	logic [dsi_pkg::DATA_W-1:0]        reg_diff;
	logic [dsi_pkg::ACC_W-1:0]         acc_diff;
	logic [dsi_pkg::DATA_W-1:0]        store_value;
	logic                              exec;
	logic                              take_irq;

	// Sign-extends a 24-bit word to accumulator width
	function automatic logic [dsi_pkg::ACC_W-1:0] widen(
		input logic [dsi_pkg::DATA_W-1:0] v
	);
		widen = {{(dsi_pkg::ACC_W-dsi_pkg::DATA_W)
			{v[dsi_pkg::SIGN_BIT]}}, v};
	endfunction

	// Decides whether an op other than swap writes its result into a data register
	function automatic logic writes_reg(
		input dsi_pkg::dsi_opcode_type op,
		input dsi_pkg::dsi_kind_type   dk
	);
		case (op)
			dsi_pkg::LOGICAL_LEFT_SHIFT_OP,
			dsi_pkg::ARITHMETIC_RIGHT_SHIFT_OP,
			dsi_pkg::LOGICAL_RIGHT_SHIFT_OP,
			dsi_pkg::XOR_OP:
				writes_reg = 1'b1;
			dsi_pkg::SUBTRACT_OP,
			dsi_pkg::HALVING_DIFFERENCE_OP,
			dsi_pkg::STORE_OP:
				writes_reg = (dk == dsi_pkg::KIND_REG);
			default:
				writes_reg = 1'b0;
		endcase
	endfunction

	assign reg_a = regs[INSTR.ra];
	assign reg_b = regs[INSTR.rb];
	assign reg_c = regs[INSTR.rc];
	assign acc_a = accs[INSTR.aa];
	assign acc_b = accs[INSTR.ab];
	assign acc_d = accs[INSTR.ad];
	assign reg_diff = reg_a - reg_b;
	assign acc_diff = acc_a - acc_b;
	assign exec = INSTR_VALID && (state != SLEEP_STATE);
	assign take_irq = IRQ && (state != HANDLER_STATE);

	dsi_shifter u_shifter (
		.value  (reg_a),
		.amount (INSTR.shamt),
		.op     (INSTR.op),
		.result (shift_result)
	);

	dsi_diffmul u_diffmul (
		.x_a     (reg_a),
		.x_b     (reg_b),
		.y_c     (reg_c),
		.acc_in  (acc_d),
		.op      (INSTR.op),
		.acc_out (diffmul_result)
	);

	// Value a store moves, by source kind
	always_comb begin
		case (INSTR.src_kind)
			dsi_pkg::KIND_IMM:
				store_value = INSTR.imm;
			dsi_pkg::KIND_ACC:
				store_value = acc_a[dsi_pkg::DATA_W-1:0];
			default:
				store_value = reg_a;
		endcase
	end

	// Sleep and interrupt sequencing
	always_comb begin
		next_state = state;
		case (state)
			RUN_STATE: begin
				if (take_irq)
					next_state = HANDLER_STATE;
				else if (exec && INSTR.op == dsi_pkg::SLEEP_OP)
					next_state = SLEEP_STATE;
			end
			SLEEP_STATE: begin
				if (IRQ)
					next_state = HANDLER_STATE;
			end
			HANDLER_STATE: begin
				if (exec && INSTR.op == dsi_pkg::INTERRUPT_EXIT_OP)
					next_state = RUN_STATE;
			end
			default:
				next_state = RUN_STATE;
		endcase
	end

	// Program counter selection; interrupts outrank the instruction
	always_comb begin
		next_pc = PC;
		if (take_irq && state != HANDLER_STATE)
			next_pc = IRQ_VECTOR;
		else if (exec) begin
			case (INSTR.op)
				dsi_pkg::RETURN_OP:
					next_pc = call_stack[call_sp - 1'b1];
				dsi_pkg::INTERRUPT_EXIT_OP:
					next_pc = irq_return;
				dsi_pkg::CALL_OP:
					next_pc = INSTR.target;
				default:
					next_pc = PC + 1'b1;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST)
			state <= RUN_STATE;
		else
			state <= next_state;
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST)
			PC <= dsi_pkg::PC_RESET;
		else
			PC <= next_pc;
	end

	// Return address of the interrupted program
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST)
			irq_return <= dsi_pkg::PC_RESET;
		else if (take_irq && state == SLEEP_STATE)
			irq_return <= PC;
		else if (take_irq)
			irq_return <= PC; // Displaced instruction runs on exit
	end

	// Subroutine return stack
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			call_sp <= '0;
			for (int i = 0; i < dsi_pkg::STACK_DEPTH; i++)
				call_stack[i] <= dsi_pkg::PC_RESET;
		end else if (exec && !take_irq) begin
			if (INSTR.op == dsi_pkg::CALL_OP) begin
				call_stack[call_sp] <= PC + 1'b1;
				call_sp <= call_sp + 1'b1;
			end else if (INSTR.op == dsi_pkg::RETURN_OP)
				call_sp <= call_sp - 1'b1;
		end
	end

	// Data register file
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < dsi_pkg::NREG; i++)
				regs[i] <= dsi_pkg::REG_RESET;
		end else if (exec && !take_irq) begin
			case (INSTR.op)
				dsi_pkg::LOGICAL_LEFT_SHIFT_OP,
				dsi_pkg::ARITHMETIC_RIGHT_SHIFT_OP,
				dsi_pkg::LOGICAL_RIGHT_SHIFT_OP:
					regs[INSTR.rd] <= shift_result;
				dsi_pkg::SUBTRACT_OP: begin
					if (INSTR.dst_kind == dsi_pkg::KIND_REG)
						regs[INSTR.rd] <= reg_diff;
				end
				dsi_pkg::HALVING_DIFFERENCE_OP: begin
					if (INSTR.dst_kind == dsi_pkg::KIND_REG)
						regs[INSTR.rd] <= $signed(reg_diff) >>> 1;
				end
				dsi_pkg::STORE_OP: begin
					if (INSTR.dst_kind == dsi_pkg::KIND_REG)
						regs[INSTR.rd] <= store_value;
				end
				dsi_pkg::SWAP_OP: begin
					if (INSTR.cond) begin
						regs[INSTR.ra] <= reg_b;
						regs[INSTR.rb] <= reg_a;
					end
				end
				dsi_pkg::XOR_OP: begin
					if (INSTR.src_kind == dsi_pkg::KIND_IMM)
						regs[INSTR.rd] <= reg_a ^ INSTR.imm;
					else
						regs[INSTR.rd] <= reg_a ^ reg_b;
				end
				default: ;
			endcase
		end
	end

	// Accumulators
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < 2; i++)
				accs[i] <= dsi_pkg::ACC_RESET;
		end else if (exec && !take_irq) begin
			case (INSTR.op)
				dsi_pkg::DIFFERENCE_MULTIPLY_OP,
				dsi_pkg::DIFFERENCE_MULTIPLY_ACCUMULATE_OP,
				dsi_pkg::DIFFERENCE_MULTIPLY_NEGATE_OP,
				dsi_pkg::DIFFERENCE_MULTIPLY_DEDUCT_OP:
					accs[INSTR.ad] <= diffmul_result;
				dsi_pkg::SUBTRACT_OP: begin
					if (INSTR.dst_kind == dsi_pkg::KIND_ACC)
						accs[INSTR.ad] <= acc_diff;
				end
				dsi_pkg::HALVING_DIFFERENCE_OP: begin
					if (INSTR.dst_kind == dsi_pkg::KIND_ACC)
						accs[INSTR.ad] <= $signed(acc_diff) >>> 1;
				end
				dsi_pkg::STORE_OP: begin
					if (INSTR.dst_kind == dsi_pkg::KIND_ACC)
						accs[INSTR.ad] <= widen(store_value);
				end
				default: ;
			endcase
		end
	end

	// Address pointers and their step registers
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < dsi_pkg::NPTR; i++) begin
				ptrs[i]  <= dsi_pkg::PTR_RESET;
				steps[i] <= dsi_pkg::STEP_RESET;
			end
		end else begin
			if (STEP_LOAD)
				steps[STEP_LOAD_SEL] <= STEP_LOAD_DATA;
			if (exec && !take_irq
					&& INSTR.op == dsi_pkg::POINTER_STEP_DECREMENT_OP)
				ptrs[INSTR.ptr] <= ptrs[INSTR.ptr]
					- steps[INSTR.ptr];
			else if (exec && !take_irq && INSTR.op == dsi_pkg::STORE_OP
					&& INSTR.dst_kind == dsi_pkg::KIND_MEM)
				ptrs[INSTR.ptr] <= ptrs[INSTR.ptr] + steps[INSTR.ptr];
		end
	end

	// Memory write port for stores
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST)
			MEM_WRITE <= '0;
		else begin
			MEM_WRITE.valid <= exec && !take_irq
				&& INSTR.op == dsi_pkg::STORE_OP
				&& INSTR.dst_kind == dsi_pkg::KIND_MEM;
			MEM_WRITE.addr <= ptrs[INSTR.ptr];
			MEM_WRITE.data <= store_value;
		end
	end

	// Result observation and status
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			RESULT       <= dsi_pkg::REG_RESET;
			RESULT_VALID <= 1'b0;
		end else begin
			RESULT_VALID <= exec && !take_irq
				&& writes_reg(INSTR.op, INSTR.dst_kind);
			case (INSTR.op)
				dsi_pkg::SUBTRACT_OP:
					RESULT <= reg_diff;
				dsi_pkg::HALVING_DIFFERENCE_OP:
					RESULT <= $signed(reg_diff) >>> 1;
				dsi_pkg::STORE_OP:
					RESULT <= store_value;
				dsi_pkg::XOR_OP:
					RESULT <= (INSTR.src_kind == dsi_pkg::KIND_IMM)
						? reg_a ^ INSTR.imm : reg_a ^ reg_b;
				default:
					RESULT <= shift_result;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			SLEEPING  <= 1'b0;
			IRQ_TAKEN <= 1'b0;
			BUSY_N    <= 1'b1;
		end else begin
			SLEEPING  <= (next_state == SLEEP_STATE);
			IRQ_TAKEN <= take_irq;
			BUSY_N    <= (next_state == SLEEP_STATE);
		end
	end
endmodule

/* File: verif/dsi_core_chk.sv */
// Concurrent checks on the execution stage, seeing its top ports only.
// Assumes one REF_CLK domain and the active-high asynchronous RST.
module dsi_core_chk (
	input  wire logic                       REF_CLK,
	input  wire logic                       RST,
	input  wire logic                       INSTR_VALID,
	input  wire dsi_pkg::dsi_instr_type     INSTR,
	input  wire logic                       IRQ,
	input  wire logic [dsi_pkg::PC_W-1:0]   IRQ_VECTOR,
	input  wire logic [dsi_pkg::PC_W-1:0]   PC,
	input  wire logic                       SLEEPING,
	input  wire logic                       IRQ_TAKEN,
	input  wire logic                       BUSY_N,
	input  wire dsi_pkg::dsi_mem_write_type MEM_WRITE,
	input  wire logic [dsi_pkg::DATA_W-1:0] RESULT,
	input  wire logic                       RESULT_VALID
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);
	logic ok;
	// Instruction accepted and not displaced by an interrupt
	assign ok = INSTR_VALID && !IRQ && !SLEEPING;
	sequence s_op(dsi_pkg::dsi_opcode_type o);
		ok && INSTR.op == o;
	endsequence
	sequence s_imm_to(dsi_pkg::dsi_kind_type k);
		s_op(dsi_pkg::STORE_OP) ##0 (INSTR.src_kind == dsi_pkg::KIND_IMM
			&& INSTR.dst_kind == k);
	endsequence
	sequence s_call_ret;
		s_op(dsi_pkg::CALL_OP) ##1 s_op(dsi_pkg::RETURN_OP);
	endsequence
	sequence s_wake;
		SLEEPING && IRQ;
	endsequence
	sleep_entry_a: assert property (
		s_op(dsi_pkg::SLEEP_OP) |=> SLEEPING && BUSY_N)
		else $error("sleep not entered");
	sleep_hold_a: assert property (
		SLEEPING && !IRQ |=> SLEEPING && $stable(PC))
		else $error("sleep left without interrupt");
	wake_up_a: assert property (
		s_wake |=> !SLEEPING && IRQ_TAKEN && PC == $past(IRQ_VECTOR))
		else $error("no wake on interrupt");
	sleep_busy_a: assert property (
		SLEEPING |-> BUSY_N)
		else $error("busy flag wrong in sleep");
	irq_pulse_a: assert property (
		IRQ_TAKEN |=> !IRQ_TAKEN)
		else $error("interrupt pulse too long");
	store_reg_a: assert property (
		s_imm_to(dsi_pkg::KIND_REG) |=> RESULT_VALID
		&& RESULT == $past(INSTR.imm))
		else $error("store to register wrong");
	store_mem_a: assert property (
		s_imm_to(dsi_pkg::KIND_MEM) |=> MEM_WRITE.valid
		&& MEM_WRITE.data == $past(INSTR.imm))
		else $error("store to memory wrong");
	call_ret_a: assert property (
		s_call_ret |=> PC == $past(PC, 2) + 16'h0001)
		else $error("return address wrong");
endmodule

bind dsi_core dsi_core_chk u_chk (.REF_CLK, .RST, .INSTR_VALID, .INSTR,
	.IRQ, .IRQ_VECTOR, .PC, .SLEEPING, .IRQ_TAKEN, .BUSY_N, .MEM_WRITE,
	.RESULT, .RESULT_VALID);

/* File: verif/tb.sv */
// Self-checking bench for the execution stage.
// Assumes dsi_pkg and dsi_core compiled first; inputs move on falling edges.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                       REF_CLK = 1'b0;
	logic                       RST = 1'b1;
	logic                       INSTR_VALID = 1'b0;
	dsi_pkg::dsi_instr_type     INSTR = '0;
	logic                       IRQ = 1'b0;
	logic [15:0]                IRQ_VECTOR = 16'h0000;
	logic [15:0]                STEP_LOAD_DATA = 16'h0000;
	logic [1:0]                 STEP_LOAD_SEL = 2'h0;
	logic                       STEP_LOAD = 1'b0;
	logic [15:0]                PC;
	logic                       SLEEPING;
	logic                       IRQ_TAKEN;
	logic                       BUSY_N;
	dsi_pkg::dsi_mem_write_type MEM_WRITE;
	logic [23:0]                RESULT;
	logic                       RESULT_VALID;
	dsi_pkg::dsi_instr_type     ins;
	int                         error_cnt = 0;
	int                         compares = 0;

	dsi_core DUT (.REF_CLK, .RST, .INSTR_VALID, .INSTR, .IRQ, .IRQ_VECTOR,
		.STEP_LOAD_DATA, .STEP_LOAD_SEL, .STEP_LOAD, .PC, .SLEEPING,
		.IRQ_TAKEN, .BUSY_N, .MEM_WRITE, .RESULT, .RESULT_VALID);

	always #50 REF_CLK = ~REF_CLK;

	task automatic stop_test();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string n, input logic [55:0] e, g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %0h seen %0h", n, e, g);
		end
	endtask

	task automatic op3(input dsi_pkg::dsi_opcode_type o,
		input logic [2:0] a, b, d);
		ins = '0;
		ins.op = o;
		ins.ra = a;
		ins.rb = b;
		ins.rd = d;
	endtask

	// Offer ins at a falling edge; return once its effects are visible
	task automatic go();
		INSTR = ins;
		INSTR_VALID = 1'b1;
		@(negedge REF_CLK);
	endtask

	task automatic idle(input string n);
		INSTR_VALID = 1'b0;
		@(negedge REF_CLK);
		$display("test %s done", n);
	endtask

	task automatic ld(input logic [2:0] d, input logic [23:0] v);
		op3(dsi_pkg::STORE_OP, 3'h0, 3'h0, d);
		ins.src_kind = dsi_pkg::KIND_IMM;
		ins.imm = v;
	endtask

	task automatic rd_chk(input dsi_pkg::dsi_kind_type k, input logic [2:0] a,
		input logic [23:0] e, input string n);
		op3(dsi_pkg::STORE_OP, a, 3'h0, 3'h7);
		ins.src_kind = k;
		ins.aa = a[0];
		go();
		chk(n, e, RESULT);
	endtask

	task automatic t_store();
		ld(3'h1, 24'hA5C3F0);
		go();
		chk("store_reg", 24'hA5C3F0, RESULT);
		ld(3'h0, 24'h123456);
		ins.dst_kind = dsi_pkg::KIND_MEM;
		go();
		chk("mem_valid", 1'b1, MEM_WRITE.valid);
		chk("mem_addr", 16'h0000, MEM_WRITE.addr);
		chk("mem_data", 24'h123456, MEM_WRITE.data);
		go();
		chk("mem_addr2", 16'h0001, MEM_WRITE.addr);
		ld(3'h0, 24'h800001);
		ins.dst_kind = dsi_pkg::KIND_ACC;
		ins.ad = 1'b1;
		go();
		rd_chk(dsi_pkg::KIND_ACC, 3'h1, 24'h800001, "acc_store");
		idle("store");
	endtask

	task automatic t_shift();
		dsi_pkg::dsi_opcode_type o [3] = '{dsi_pkg::LOGICAL_LEFT_SHIFT_OP,
			dsi_pkg::ARITHMETIC_RIGHT_SHIFT_OP,
			dsi_pkg::LOGICAL_RIGHT_SHIFT_OP};
		logic [23:0] e [3] = '{24'h123450, 24'hF81234, 24'h081234};
		ld(3'h1, 24'h812345);
		go();
		for (int i = 0; i < 3; i++) begin
			op3(o[i], 3'h1, 3'h0, 3'h2);
			ins.shamt = 5'h04;
			go();
			chk("shift", e[i], RESULT);
		end
		idle("shift");
	endtask

	task automatic t_sub();
		ld(3'h1, 24'h000005);
		go();
		ld(3'h2, 24'h000007);
		go();
		op3(dsi_pkg::SUBTRACT_OP, 3'h1, 3'h2, 3'h3);
		go();
		chk("sub", 24'hFFFFFE, RESULT);
		op3(dsi_pkg::HALVING_DIFFERENCE_OP, 3'h1, 3'h2, 3'h3);
		go();
		chk("half_neg", 24'hFFFFFF, RESULT);
		op3(dsi_pkg::HALVING_DIFFERENCE_OP, 3'h2, 3'h1, 3'h3);
		go();
		chk("half_pos", 24'h000001, RESULT);
		op3(dsi_pkg::SUBTRACT_OP, 3'h0, 3'h0, 3'h0);
		ins.dst_kind = dsi_pkg::KIND_ACC;
		ins.ab = 1'b1;
		go();
		rd_chk(dsi_pkg::KIND_ACC, 3'h0, 24'h7FFFFF, "sub_acc");
		op3(dsi_pkg::HALVING_DIFFERENCE_OP, 3'h0, 3'h0, 3'h0);
		ins.dst_kind = dsi_pkg::KIND_ACC;
		ins.aa = 1'b1;
		go();
		rd_chk(dsi_pkg::KIND_ACC, 3'h0, 24'h800001, "half_acc");
		idle("sub");
	endtask

	task automatic t_mul();
		dsi_pkg::dsi_opcode_type o [4] = '{dsi_pkg::DIFFERENCE_MULTIPLY_OP,
			dsi_pkg::DIFFERENCE_MULTIPLY_ACCUMULATE_OP,
			dsi_pkg::DIFFERENCE_MULTIPLY_DEDUCT_OP,
			dsi_pkg::DIFFERENCE_MULTIPLY_NEGATE_OP};
		logic [23:0] e [4] = '{24'hFFFFF7, 24'hFFFFEE, 24'hFFFFF7, 24'h000009};
		dsi_pkg::dsi_kind_type ka = dsi_pkg::KIND_ACC;
		ld(3'h1, 24'h000002);
		go();
		ld(3'h2, 24'h000005);
		go();
		ld(3'h3, 24'h000003);
		go();
		for (int i = 0; i < 4; i++) begin
			op3(o[i], 3'h1, 3'h2, 3'h0);
			ins.rc = 3'h3;
			go();
			rd_chk(ka, 3'h0, e[i], "diffmul");
		end
		idle("diffmul");
	endtask

	task automatic t_swap_xor();
		ld(3'h1, 24'h111111);
		go();
		ld(3'h2, 24'h222222);
		go();
		op3(dsi_pkg::SWAP_OP, 3'h1, 3'h2, 3'h0);
		go();
		rd_chk(dsi_pkg::KIND_REG, 3'h1, 24'h111111, "swap_off");
		op3(dsi_pkg::SWAP_OP, 3'h1, 3'h2, 3'h0);
		ins.cond = 1'b1;
		go();
		rd_chk(dsi_pkg::KIND_REG, 3'h1, 24'h222222, "swap_a");
		rd_chk(dsi_pkg::KIND_REG, 3'h2, 24'h111111, "swap_b");
		op3(dsi_pkg::XOR_OP, 3'h1, 3'h2, 3'h3);
		go();
		chk("xor_reg", 24'h333333, RESULT);
		op3(dsi_pkg::XOR_OP, 3'h1, 3'h0, 3'h3);
		ins.src_kind = dsi_pkg::KIND_IMM;
		ins.imm = 24'hFFFFFF;
		go();
		chk("xor_imm", 24'hDDDDDD, RESULT);
		idle("swap_xor");
	endtask

	task automatic t_step();
		STEP_LOAD_SEL = 2'h1;
		STEP_LOAD_DATA = 16'h0003;
		STEP_LOAD = 1'b1;
		@(negedge REF_CLK);
		STEP_LOAD = 1'b0;
		op3(dsi_pkg::POINTER_STEP_DECREMENT_OP, 3'h0, 3'h0, 3'h0);
		ins.ptr = 2'h1;
		go();
		ld(3'h0, 24'h00000A);
		ins.dst_kind = dsi_pkg::KIND_MEM;
		ins.ptr = 2'h1;
		go();
		chk("step_addr", 16'hFFFD, MEM_WRITE.addr);
		go();
		chk("step_wrap", 16'h0000, MEM_WRITE.addr);
		idle("step");
	endtask

	task automatic t_flow();
		op3(dsi_pkg::CALL_OP, 3'h0, 3'h0, 3'h0);
		ins.target = 16'h0040;
		go();
		ins.target = 16'h0200;
		go();
		chk("call", 16'h0200, PC);
		op3(dsi_pkg::RETURN_OP, 3'h0, 3'h0, 3'h0);
		go();
		chk("return", 16'h0041, PC);
		op3(dsi_pkg::SLEEP_OP, 3'h0, 3'h0, 3'h0);
		go();
		chk("asleep", 2'h3, {SLEEPING, BUSY_N});
		ld(3'h0, 24'h00000B);
		ins.dst_kind = dsi_pkg::KIND_MEM;
		go();
		chk("ignored", 17'h00042, {MEM_WRITE.valid, PC});
		INSTR_VALID = 1'b0;
		IRQ_VECTOR = 16'h0300;
		IRQ = 1'b1;
		@(negedge REF_CLK);
		chk("wake", 18'h10300, {SLEEPING, IRQ_TAKEN, PC});
		IRQ = 1'b0;
		op3(dsi_pkg::NOP_OP, 3'h0, 3'h0, 3'h0);
		go();
		op3(dsi_pkg::INTERRUPT_EXIT_OP, 3'h0, 3'h0, 3'h0);
		go();
		chk("resume", 16'h0042, PC);
		ld(3'h4, 24'h00000C);
		IRQ = 1'b1;
		go();
		chk("irq_run", 18'h20300, {IRQ_TAKEN, RESULT_VALID, PC});
		IRQ = 1'b0;
		op3(dsi_pkg::INTERRUPT_EXIT_OP, 3'h0, 3'h0, 3'h0);
		go();
		chk("resume_run", 16'h0042, PC);
		idle("flow");
	endtask

	initial begin
		repeat (4) @(negedge REF_CLK);
		RST = 1'b0;
		t_store();
		t_shift();
		t_sub();
		t_mul();
		t_swap_xor();
		t_step();
		t_flow();
		stop_test();
	end

	// Whole run is about 63 cycles
	initial begin
		#50000;
		error_cnt++;
		stop_test();
	end
endmodule
